/* File: src/pic_defines.svh */
// Purpose: Constants of the priority interrupt controller
// Assumes: Included by bare name from the design files
// Notes:   Bit positions refer to the 8-bit host data bus
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

// ==========================================================
// Command word field positions
`define PIC_INIT1_FLAG 4
`define PIC_INIT1_TRIG 3
`define PIC_INIT1_INTV 2
`define PIC_INIT1_LONE 1
`define PIC_INIT1_NEED4 0
`define PIC_OP_KIND 3
`define PIC_OP3_ENSPEC 6
`define PIC_OP3_SPEC 5
`define PIC_OP3_POLL 2
`define PIC_OP3_RDEN 1
`define PIC_OP3_RDSEL 0

// ==========================================================
// Fixed values and reset values
`define PIC_CALL_OPCODE 8'hCD
`define PIC_SPUR_LEVEL 3'h7
`define PIC_LOWEST_RST 3'h7
`define PIC_SYNC_RST 25'h1FF_FFFF
`define PIC_LAST_CALL 2'h3
`define PIC_LAST_PTR 2'h2

`endif

/* File: src/pic_pkg.sv */
// Purpose: Types shared by the priority interrupt controller
// Assumes: Constants live in pic_defines.svh
// Notes:   Binary state codes are written out
package pic_pkg;
   typedef enum logic [1:0] {
      PIC_READY = 2'b00,
      PIC_WAIT2 = 2'b01,
      PIC_WAIT3 = 2'b10,
      PIC_WAIT4 = 2'b11
   } pic_init_t;
endpackage : pic_pkg

/* File: src/pic_res_if.sv */
// Purpose: Carries request and service vectors to the priority resolver
// Assumes: One controller and one resolver per instance
// Notes:   Results are combinational
`timescale 1ns/10ps
interface pic_res_if;
   logic [7:0] req_vec;
   logic [7:0] svc_vec;
   logic [2:0] lowest;
   logic req_ok;
   logic [2:0] req_lvl;
   logic svc_any;
   logic [2:0] svc_lvl;
   modport ctl(output req_vec, svc_vec, lowest, input req_ok, req_lvl, svc_any, svc_lvl);
   modport res(input req_vec, svc_vec, lowest, output req_ok, req_lvl, svc_any, svc_lvl);
endinterface : pic_res_if

/* File: src/pic_resolve.sv */
// Purpose: Rotating priority resolver for eight levels
// Assumes: Level after lowest is the highest priority
// Notes:   A request wins only against strictly lower in-service priority
`timescale 1ns/10ps
module pic_resolve #(parameter int WIDTH = 8) (
   pic_res_if.res rif
);
   if (WIDTH != 8) begin : g_chk
      $error("pic_resolve: only eight levels are served");
   end

   // ==========================================================
   // Rank search: bit 3 set when any bit is set
   function automatic logic [3:0] first_rank(input logic [7:0] v, input logic [2:0] low);
      logic [15:0] dbl;
      logic [3:0] res;
      dbl = {v, v} >> (3'(low + 3'd1));
      res = 4'h0;
      for (int k = 7; k >= 0; k--) begin
         if (dbl[k]) begin
            res = {1'b1, 3'(k)};
         end
      end
      return res;
   endfunction : first_rank

   logic [3:0] r_rank;
   logic [3:0] s_rank;
   assign r_rank = first_rank(rif.req_vec, rif.lowest);
   assign s_rank = first_rank(rif.svc_vec, rif.lowest);
   assign rif.req_ok = r_rank[3] & (~s_rank[3] | (r_rank[2:0] < s_rank[2:0]));
   assign rif.req_lvl = 3'(r_rank[2:0] + rif.lowest + 3'd1);
   assign rif.svc_any = s_rank[3];
   assign rif.svc_lvl = 3'(s_rank[2:0] + rif.lowest + 3'd1);
endmodule : pic_resolve

/* File: src/pic_core.sv */
// Purpose: Eight-input priority interrupt controller behind a host port
// Assumes: All pins are asynchronous to clk and pass two flip-flops
// Notes:   Strobes act on their synchronised edges, a few cycles late
//
// What this block does
// - Pointer mode, first acknowledge: data bus left undriven.
// - Pointer mode, second acknowledge: drive 8-bit pointer, ending the cycle.
// - Pointer mode with auto end: in-service clears at second pulse trailing edge.
// - Rising request sets pending bit; mask and priority decide the interrupt.
// - Request gone before first acknowledge: answer as line 7, no in-service bit.
// - Call mode, first acknowledge: drive call opcode CD hex.
// - Call mode: low vector byte on pulse two, high byte on three.
// - Interval four: address bits 7..5, level in 4..2, zeros below.
// - Read strobe low drives status; port select and the poll and read-select bits pick the word.
// - Cascade lines are outputs in a cascaded master, inputs in slave; a lone chip leaves them undriven.
// - Write, port select low, data bit 4 set starts initialization.
// - First word clears mask, special mask, sets line 7 lowest, pending reads.
// - Lone-chip flag skips third word; else third word names slaves.
// - Cascaded call mode: master gives opcode, slave vectors; pointer from slave.
// - Master when unbuffered with pin high, or buffered with primary bit set.
// - Slave matches its 3-bit code on cascade lines, then outputs vector.
// - Fourth word only when requested; sets nesting, buffer, role, auto end, mode.
// - Rotate with end rotates on non-specific end; rotate alone sets flip-flop.
// - Specific end clears named level; non-specific clears highest in service.
// - Special mask mode: end never clears masked in-service bits.
// - Auto end mode ends at last pulse until a fourth word, or a first word without one, changes it.
// - Auto rotation makes the just serviced level lowest priority.
// - Read with port select high returns the mask register.
// - Status selection persists; poll overrides status read.
// - Edge mode needs a rising edge; level mode a held high.
`timescale 1ns/10ps
`include "pic_defines.svh"
module pic_core import pic_pkg::*; (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic port_select,
   input wire logic [7:0] d_in,
   output logic [7:0] d_out,
   output logic d_oe,
   input wire logic irq_ack_n,
   output logic int_out,
   input wire logic [7:0] req_lines,
   input wire logic [2:0] cas_in,
   output logic [2:0] cas_out,
   output logic cas_oe,
   input wire logic primary_pin_n
);
   function automatic logic [7:0] pic_bit(input logic [2:0] n);
      return 8'h01 << n;
   endfunction : pic_bit

   // ==========================================================
   // Pin synchronisers; third stage gives edges
   logic [24:0] sync1, sync2, sync3;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1 <= `PIC_SYNC_RST;
         sync2 <= `PIC_SYNC_RST;
         sync3 <= `PIC_SYNC_RST;
      end else begin
         sync1 <= {req_lines, d_in, cas_in, rd_n, wr_n, cs_n, port_select, irq_ack_n, primary_pin_n};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   logic [7:0] s_req, s_d, p_req, p_d;
   logic [2:0] s_cas, p_cas;
   logic s_rd_n, s_wr_n, s_cs_n, s_sel, s_ack_n, s_prim;
   logic p_rd_n, p_wr_n, p_cs_n, p_sel, p_ack_n, p_prim;
   assign {s_req, s_d, s_cas, s_rd_n, s_wr_n, s_cs_n, s_sel, s_ack_n, s_prim} = sync2;
   assign {p_req, p_d, p_cas, p_rd_n, p_wr_n, p_cs_n, p_sel, p_ack_n, p_prim} = sync3;

   // ==========================================================
   // State
   pic_init_t init_st;
   logic [7:0] mask_reg, in_service_reg, arm, vec_hi, casc_cfg;
   logic [2:0] lowest, addr_hi, ack_lvl;
   logic [1:0] ack_cnt;
   logic lvl_mode, intv4, lone_chip_flag, need_fourth_word;
   logic nest_mode, buf_mode, ms_bit, auto_end_mode, ptr_mode;
   logic special_mask_mode, read_service, poll, rot_auto, spur, sel;

   pic_res_if rif();
   pic_resolve #(.WIDTH(8)) u_res (.rif(rif.res));

   // ==========================================================
   // Host port decode; write data is taken as it stood before the rising strobe
   logic wr_ev, w_init1, w_hi, w_op2, w_op3, rd_act, rd_end, ready;
   logic [7:0] wd;
   logic [2:0] cmd, level_field;
   assign ready = (init_st == PIC_READY);
   assign wr_ev = s_wr_n & ~p_wr_n & ~p_cs_n;
   assign wd = p_d;
   assign w_init1 = wr_ev & ~p_sel & wd[`PIC_INIT1_FLAG];
   assign w_hi = wr_ev & p_sel;
   assign w_op2 = wr_ev & ~p_sel & ~wd[`PIC_INIT1_FLAG] & ~wd[`PIC_OP_KIND] & ready;
   assign w_op3 = wr_ev & ~p_sel & ~wd[`PIC_INIT1_FLAG] & wd[`PIC_OP_KIND] & ready;
   assign rd_act = ~s_rd_n & ~s_cs_n;
   assign rd_end = s_rd_n & ~p_rd_n & ~p_cs_n & ~p_sel;
   assign cmd = wd[7:5];
   assign level_field = wd[2:0];

   // Word 2 commands: rotate, level choice, end
   logic ns_cmd, sp_cmd, rot_ns, rot_sp, set_prio, rot_set, rot_clr;
   assign ns_cmd = w_op2 & (cmd == 3'b001 | cmd == 3'b101);
   assign sp_cmd = w_op2 & (cmd == 3'b011 | cmd == 3'b111);
   assign rot_ns = w_op2 & (cmd == 3'b101);
   assign rot_sp = w_op2 & (cmd == 3'b111);
   assign set_prio = w_op2 & (cmd == 3'b110);
   assign rot_set = w_op2 & (cmd == 3'b100);
   assign rot_clr = w_op2 & (cmd == 3'b000);

   // ==========================================================
   // Acknowledge sequence and cascade
   logic ack_fall, ack_rise, acking, is_master, slave_line, cas_hit, own_vec;
   logic involved, seq_end, take1, auto_end, poll_take, next_sel;
   logic [1:0] last_cnt;
   assign ack_fall = ~s_ack_n & p_ack_n;
   assign ack_rise = s_ack_n & ~p_ack_n;
   assign acking = (ack_cnt != 2'h0);
   assign is_master = buf_mode ? ms_bit : s_prim;
   assign slave_line = ~lone_chip_flag & is_master & casc_cfg[ack_lvl];
   assign cas_hit = ~lone_chip_flag & ~is_master & (s_cas == casc_cfg[2:0]);
   assign involved = lone_chip_flag | is_master | sel;
   assign own_vec = lone_chip_flag | (is_master ? ~slave_line : sel);
   assign last_cnt = ptr_mode ? `PIC_LAST_PTR : `PIC_LAST_CALL;
   assign seq_end = ack_rise & acking & (ack_cnt >= last_cnt);
   assign take1 = ack_rise & (ack_cnt == 2'h1) & involved & ~spur;
   assign auto_end = seq_end & auto_end_mode & involved;
   assign poll_take = rd_end & poll & rif.req_ok;
   assign next_sel = (ack_fall & ~acking) ? 1'b0 : (sel | (~s_ack_n & acking & cas_hit));

   // ==========================================================
   // Pending, service and priority update
   logic [7:0] pending_reg, svc_vec, set_vec, clr_vec, next_service, next_arm;
   logic [2:0] set_lvl, next_low;
   logic ns_clear, sp_ok;
   assign pending_reg = s_req & ({8{lvl_mode}} | arm);
   assign svc_vec = special_mask_mode ? (in_service_reg & ~mask_reg) : in_service_reg;
   assign rif.req_vec = pending_reg & ~mask_reg;
   assign rif.svc_vec = svc_vec;
   assign rif.lowest = lowest;
   assign ns_clear = (ns_cmd | auto_end) & rif.svc_any;
   assign sp_ok = sp_cmd & ~(special_mask_mode & mask_reg[level_field]);
   assign set_lvl = poll_take ? rif.req_lvl : ack_lvl;
   assign set_vec = (take1 | poll_take) ? pic_bit(set_lvl) : 8'h00;
   assign clr_vec = (ns_clear ? pic_bit(rif.svc_lvl) : 8'h00) | (sp_ok ? pic_bit(level_field) : 8'h00);
   assign next_service = (in_service_reg & ~clr_vec) | set_vec;
   assign next_arm = (arm & ~set_vec) | (s_req & ~p_req);
   assign next_low = w_init1 ? `PIC_LOWEST_RST :
                     (rot_ns & rif.svc_any) ? rif.svc_lvl :
                     (rot_sp | set_prio) ? level_field :
                     (auto_end & rot_auto & rif.svc_any) ? rif.svc_lvl : lowest;

   // ==========================================================
   // Data bus selection; acknowledge takes precedence over reads
   logic [7:0] low_byte, ptr_byte, ack_byte, status_byte, next_dout;
   logic ack_oe, next_oe;
   assign low_byte = intv4 ? {addr_hi, ack_lvl, 2'b00} : {addr_hi[2:1], ack_lvl, 3'b000};
   assign ptr_byte = {vec_hi[7:3], ack_lvl};
   assign ack_oe = ~s_ack_n & (((ack_cnt == 2'h1) & ~ptr_mode & (lone_chip_flag | is_master)) |
                   ((ack_cnt == 2'h2) & own_vec) |
                   ((ack_cnt == 2'h3) & ~ptr_mode & own_vec));
   assign ack_byte = (ack_cnt == 2'h1) ? `PIC_CALL_OPCODE :
                     (ack_cnt == 2'h2) ? (ptr_mode ? ptr_byte : low_byte) : vec_hi;
   assign status_byte = s_sel ? mask_reg :
                        poll ? {rif.req_ok, 4'h0, rif.req_lvl} :
                        read_service ? in_service_reg : pending_reg;
   assign next_oe = ack_oe | (rd_act & s_ack_n);
   assign next_dout = ack_oe ? ack_byte : status_byte;

   // ==========================================================
   // Configuration and command words
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         init_st <= PIC_READY;
         mask_reg <= 8'h00;
         addr_hi <= 3'h0;
         vec_hi <= 8'h00;
         casc_cfg <= 8'h00;
         {lvl_mode, intv4, lone_chip_flag, need_fourth_word} <= 4'h0;
         {nest_mode, buf_mode, ms_bit, auto_end_mode, ptr_mode} <= 5'h00;
         {special_mask_mode, read_service, poll, rot_auto} <= 4'h0;
      end else if (w_init1) begin
         init_st <= PIC_WAIT2;
         mask_reg <= 8'h00;
         addr_hi <= wd[7:5];
         lvl_mode <= wd[`PIC_INIT1_TRIG];
         intv4 <= wd[`PIC_INIT1_INTV];
         lone_chip_flag <= wd[`PIC_INIT1_LONE];
         need_fourth_word <= wd[`PIC_INIT1_NEED4];
         special_mask_mode <= 1'b0;
         read_service <= 1'b0;
         poll <= 1'b0;
         if (!wd[`PIC_INIT1_NEED4]) begin
            {nest_mode, buf_mode, ms_bit, auto_end_mode, ptr_mode} <= 5'h00;
         end
      end else if (w_hi) begin
         case (init_st)
            PIC_WAIT2: begin
               vec_hi <= wd;
               init_st <= !lone_chip_flag ? PIC_WAIT3 : (need_fourth_word ? PIC_WAIT4 : PIC_READY);
            end
            PIC_WAIT3: begin
               casc_cfg <= wd;
               init_st <= need_fourth_word ? PIC_WAIT4 : PIC_READY;
            end
            PIC_WAIT4: begin
               {nest_mode, buf_mode, ms_bit, auto_end_mode, ptr_mode} <= wd[4:0];
               init_st <= PIC_READY;
            end
            PIC_READY: mask_reg <= wd;
            default: init_st <= PIC_READY;
         endcase
      end else if (w_op3) begin
         if (wd[`PIC_OP3_ENSPEC]) begin
            special_mask_mode <= wd[`PIC_OP3_SPEC];
         end
         poll <= wd[`PIC_OP3_POLL];
         if (wd[`PIC_OP3_RDEN]) begin
            read_service <= wd[`PIC_OP3_RDSEL];
         end
      end else if (rot_set | rot_clr) begin
         rot_auto <= rot_set;
      end else if (rd_end) begin
         poll <= 1'b0;
      end
   end

   // ==========================================================
   // Service state, acknowledge counter and pins
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         in_service_reg <= 8'h00;
         arm <= 8'h00;
         lowest <= `PIC_LOWEST_RST;
         ack_cnt <= 2'h0;
         ack_lvl <= 3'h0;
         spur <= 1'b0;
         sel <= 1'b0;
         int_out <= 1'b0;
         d_out <= 8'h00;
         d_oe <= 1'b0;
         cas_out <= 3'h0;
         cas_oe <= 1'b0;
      end else begin
         in_service_reg <= next_service;
         arm <= next_arm;
         lowest <= next_low;
         sel <= next_sel;
         if (ack_fall) begin
            ack_cnt <= (ack_cnt == 2'h3) ? ack_cnt : 2'(ack_cnt + 2'h1);
            if (!acking) begin
               ack_lvl <= rif.req_ok ? rif.req_lvl : `PIC_SPUR_LEVEL;
               spur <= ~rif.req_ok;
            end
         end else if (seq_end) begin
            ack_cnt <= 2'h0;
         end
         int_out <= ready & rif.req_ok & ~acking;
         d_out <= next_dout;
         d_oe <= next_oe;
         cas_out <= (acking & slave_line) ? ack_lvl : 3'h0;
         cas_oe <= is_master & ~lone_chip_flag;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!arst_n);

   sequence s_ptr_step(logic [1:0] n);
      ptr_mode && ack_cnt == n && !s_ack_n;
   endsequence

   a_ptr_first_quiet: assert property (s_ptr_step(2'h1) |=> !d_oe)
      else $error("bus driven on first pointer pulse");
   a_ptr_second_out: assert property (s_ptr_step(2'h2) ##0 own_vec |=> d_oe && d_out == $past(ptr_byte))
      else $error("pointer not driven on second pulse");
   a_call_opcode_out: assert property (!ptr_mode && ack_cnt == 2'h1 && !s_ack_n && is_master
      |=> d_oe && d_out == `PIC_CALL_OPCODE)
      else $error("call opcode missing");
   a_call_low_byte: assert property (!ptr_mode && ack_cnt == 2'h2 && !s_ack_n && own_vec
      |=> d_out == $past(low_byte))
      else $error("low vector byte wrong");
   a_auto_end_clear: assert property (auto_end && rif.svc_any && !take1
      |=> !in_service_reg[$past(rif.svc_lvl)])
      else $error("auto end left bit set");
   a_init_clears_state: assert property (w_init1 |=> mask_reg == 8'h00 && !special_mask_mode
      && !read_service && lowest == `PIC_LOWEST_RST && init_st == PIC_WAIT2)
      else $error("first word did not clear state");
   a_mask_read_back: assert property (rd_act && s_sel && s_ack_n |=> d_oe && d_out == $past(mask_reg))
      else $error("mask read wrong");
   a_spurious_level: assert property (ack_fall && !acking && !rif.req_ok
      |=> ack_lvl == `PIC_SPUR_LEVEL && spur ##0 (!take1)[*1])
      else $error("spurious acknowledge mishandled");
   a_cas_direction: assert property (1'b1 |=> cas_oe == $past(is_master && !lone_chip_flag))
      else $error("cascade direction wrong");
   a_masked_quiet: assert property ((pending_reg & ~mask_reg) == 8'h00 |=> !int_out)
      else $error("masked request raised interrupt");
   a_lone_skip_third: assert property (init_st == PIC_WAIT2 && w_hi && lone_chip_flag && !need_fourth_word
      |=> init_st == PIC_READY)
      else $error("third word not skipped");
endmodule : pic_core

/* File: dv/pic_host_model.sv */
// Purpose: Host processor model driving the register port and acknowledge pulses
// Assumes: Strobes stay low and high for well over three clocks each
// Notes:   An undriven data bus toggles every cycle so a stale byte cannot pass
`timescale 1ns/10ps
module pic_host_model (
   input wire logic clk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic port_select,
   output logic irq_ack_n,
   output logic [7:0] d_in,
   input wire logic [7:0] d_out,
   input wire logic d_oe
);
   logic drv;
   logic [7:0] wdata;
   logic [7:0] last_bus;

   // ==========================================================
   // Bus resolution
   assign d_in = d_oe ? d_out : (drv ? wdata : ~last_bus);

   always_ff @(posedge clk) begin
      last_bus <= d_in;
   end

   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      port_select = 1'b0;
      irq_ack_n = 1'b1;
      drv = 1'b0;
      wdata = 8'h00;
      last_bus = 8'h00;
   end

   // ==========================================================
   // Bus cycles
   task automatic wr(input logic a, input logic [7:0] d);
      @(posedge clk);
      cs_n <= 1'b0;
      port_select <= a;
      wdata <= d;
      drv <= 1'b1;
      wr_n <= 1'b0;
      repeat (5) @(posedge clk);
      wr_n <= 1'b1;
      // Data held past the rising strobe so the synchroniser sees it settled
      repeat (2) @(posedge clk);
      cs_n <= 1'b1;
      drv <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : wr

   task automatic rd(input logic a, output logic [7:0] d, output logic oe);
      @(posedge clk);
      cs_n <= 1'b0;
      port_select <= a;
      rd_n <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      d = d_out;
      oe = d_oe;
      @(posedge clk);
      rd_n <= 1'b1;
      cs_n <= 1'b1;
      repeat (5) @(posedge clk);
   endtask : rd

   task automatic ack(output logic [7:0] d, output logic oe);
      @(posedge clk);
      irq_ack_n <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      d = d_out;
      oe = d_oe;
      @(posedge clk);
      irq_ack_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : ack
endmodule : pic_host_model

/* File: dv/pic_core_tb.sv */
// Purpose: Self-checking bench for the priority interrupt controller
// Assumes: Host model owns the bus strobes; bench drives requests and pins
// Notes:   Each scenario task judges its own results
`timescale 1ns/10ps
module pic_core_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] req_lines = 8'h00;
   logic [2:0] cas_in = 3'h0;
   logic primary_pin_n = 1'b1;
   logic cs_n, rd_n, wr_n, port_select, irq_ack_n, int_out, d_oe, cas_oe, oe;
   logic [7:0] d_in, d_out, got;
   logic [2:0] cas_out;
   int errors = 0;
   int compares = 0;

   always #4 clk = ~clk;

   pic_core dut_u (.clk(clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
      .port_select(port_select), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .irq_ack_n(irq_ack_n),
      .int_out(int_out), .req_lines(req_lines), .cas_in(cas_in), .cas_out(cas_out), .cas_oe(cas_oe),
      .primary_pin_n(primary_pin_n));

   pic_host_model host_u (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .port_select(port_select),
      .irq_ack_n(irq_ack_n), .d_in(d_in), .d_out(d_out), .d_oe(d_oe));

   // ==========================================================
   // Shared tasks
   task automatic finish_test;
      if (errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      compares++;
      if (seen !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, seen);
         errors++;
      end
   endtask : chk

   task automatic wait_int;
      int n;
      n = 0;
      while (int_out !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (int_out !== 1'b1) begin
         $display("wrong value int_out expected 1 seen %b", int_out);
         errors++;
         finish_test();
      end
   endtask : wait_int

   task automatic init(input logic [7:0] w1, input logic [7:0] w2, input logic [7:0] w3, input logic [7:0] w4);
      host_u.wr(1'b0, w1);
      host_u.wr(1'b1, w2);
      if (!w1[1]) host_u.wr(1'b1, w3);
      if (w1[0]) host_u.wr(1'b1, w4);
   endtask : init

   // ==========================================================
   // Scenarios
   task automatic t_mask_reg;
      init(8'hF6, 8'h12, 8'h00, 8'h00);
      host_u.wr(1'b1, 8'hA5);
      host_u.rd(1'b1, got, oe);
      chk("mask readback", 8'hA5, got);
      chk("read drive", 8'h01, {7'h0, oe});
      host_u.wr(1'b0, 8'h0B);
      init(8'hF6, 8'h12, 8'h00, 8'h00);
      host_u.rd(1'b1, got, oe);
      chk("mask after first word", 8'h00, got);
   endtask : t_mask_reg

   task automatic t_call;
      host_u.wr(1'b1, 8'h10);
      req_lines <= 8'h10;
      repeat (20) @(negedge clk);
      chk("int_out while masked", 8'h00, {7'h0, int_out});
      host_u.rd(1'b0, got, oe);
      chk("pending read", 8'h10, got);
      host_u.wr(1'b1, 8'h00);
      wait_int();
      host_u.ack(got, oe);
      chk("call opcode", 8'hCD, got);
      host_u.ack(got, oe);
      chk("low vector byte", 8'hF0, got);
      host_u.ack(got, oe);
      chk("high vector byte", 8'h12, got);
      host_u.wr(1'b0, 8'h0B);
      host_u.rd(1'b0, got, oe);
      chk("in service", 8'h10, got);
      host_u.wr(1'b0, 8'h20);
      host_u.rd(1'b0, got, oe);
      chk("in service after end", 8'h00, got);
      req_lines <= 8'h00;
   endtask : t_call

   task automatic t_pointer_auto;
      init(8'h13, 8'h48, 8'h00, 8'h03);
      req_lines <= 8'h04;
      wait_int();
      host_u.ack(got, oe);
      chk("first pulse drive", 8'h00, {7'h0, oe});
      host_u.ack(got, oe);
      chk("pointer", 8'h4A, got);
      host_u.wr(1'b0, 8'h0B);
      host_u.rd(1'b0, got, oe);
      chk("in service auto end", 8'h00, got);
   endtask : t_pointer_auto

   task automatic t_specific_end;
      req_lines <= 8'h00;
      init(8'h13, 8'h48, 8'h00, 8'h01);
      req_lines <= 8'h20;
      wait_int();
      host_u.ack(got, oe);
      host_u.ack(got, oe);
      chk("pointer level five", 8'h4D, got);
      host_u.wr(1'b0, 8'h0B);
      host_u.wr(1'b0, 8'h64);
      host_u.rd(1'b0, got, oe);
      chk("other level end", 8'h20, got);
      host_u.wr(1'b0, 8'h65);
      host_u.rd(1'b0, got, oe);
      chk("named level end", 8'h00, got);
      req_lines <= 8'h00;
   endtask : t_specific_end

   task automatic t_spurious;
      @(posedge clk);
      req_lines <= 8'h02;
      wait_int();
      @(posedge clk);
      req_lines <= 8'h00;
      repeat (6) @(posedge clk);
      host_u.ack(got, oe);
      host_u.ack(got, oe);
      chk("spurious pointer", 8'h4F, got);
      host_u.rd(1'b0, got, oe);
      chk("spurious in service", 8'h00, got);
   endtask : t_spurious

   task automatic t_cascade;
      init(8'h10, 8'h00, 8'h08, 8'h00);
      repeat (4) @(negedge clk);
      chk("master cascade drive", 8'h01, {7'h0, cas_oe});
      @(posedge clk);
      req_lines <= 8'h08;
      wait_int();
      host_u.ack(got, oe);
      chk("master opcode", 8'hCD, got);
      chk("cascade code", 8'h03, {5'h00, cas_out});
      host_u.ack(got, oe);
      chk("master quiet on vector", 8'h00, {7'h0, oe});
      host_u.ack(got, oe);
      host_u.wr(1'b0, 8'h20);
      req_lines <= 8'h00;
      @(posedge clk);
      primary_pin_n <= 1'b0;
      cas_in <= 3'h2;
      init(8'h10, 8'h5A, 8'h02, 8'h00);
      repeat (4) @(negedge clk);
      chk("slave cascade drive", 8'h00, {7'h0, cas_oe});
      @(posedge clk);
      req_lines <= 8'h40;
      wait_int();
      host_u.ack(got, oe);
      chk("slave quiet on opcode", 8'h00, {7'h0, oe});
      host_u.ack(got, oe);
      chk("slave low byte", 8'h30, got);
      host_u.ack(got, oe);
      chk("slave high byte", 8'h5A, got);
      host_u.wr(1'b0, 8'h20);
      req_lines <= 8'h00;
   endtask : t_cascade

   // ==========================================================
   // Main sequence
   initial begin
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (5) @(negedge clk);
      chk("int_out after reset", 8'h00, {7'h0, int_out});
      chk("d_oe after reset", 8'h00, {7'h0, d_oe});
      t_mask_reg();
      t_call();
      t_pointer_auto();
      t_specific_end();
      t_spurious();
      t_cascade();
      finish_test();
   end

   // A hang anywhere ends the run as a failure
   initial begin
      repeat (100000) @(posedge clk);
      errors++;
      finish_test();
   end
endmodule : pic_core_tb
